// ### bzs_contact_sync.sv
// Contact synchronisers and disconnect status decoding
`timescale 1ns/1ps
module bzs_contact_sync import bzs_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N_DISC-1:0] disc_no_raw,
  input wire logic [N_DISC-1:0] disc_nc_raw,
  input wire logic [N_TERM-1:0] bkr_raw,
  output logic [N_DISC-1:0] disc_closed,
  output logic [N_TERM-1:0] bkr_closed
);
  logic [N_DISC-1:0] no_s1_ff, no_s2_ff, nc_s1_ff, nc_s2_ff;
  logic [N_TERM-1:0] bk_s1_ff, bk_s2_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      no_s1_ff <= '0;
      no_s2_ff <= '0;
      nc_s1_ff <= '0;
      nc_s2_ff <= '0;
      bk_s1_ff <= '0;
      bk_s2_ff <= '0;
    end else begin
      no_s1_ff <= disc_no_raw;
      no_s2_ff <= no_s1_ff;
      nc_s1_ff <= disc_nc_raw;
      nc_s2_ff <= nc_s1_ff;
      bk_s1_ff <= bkr_raw;
      bk_s2_ff <= bk_s1_ff;
    end
  end

  // Both contacts lost or both made counts as closed: fail toward inclusion
  assign disc_closed = ~(~no_s2_ff & nc_s2_ff);
  assign bkr_closed = bk_s2_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_disc_decode: assert property ($past(reset_n) && $past(reset_n, 2) |->
    disc_closed == ~(~$past(disc_no_raw, 2) & $past(disc_nc_raw, 2)))
    else $error("disconnect status decoded wrongly");
endmodule

// ### bzs_diff_elem.sv
// Adaptive differential element with external fault and CT failure detection
`timescale 1ns/1ps
module bzs_diff_elem import bzs_pkg::*; #(
  parameter int HOLD_CYC = EFD_MAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  bzs_elem_if.elem e
);
  logic [SUM_W-1:0] op_abs, op_prev_ff, rst_prev_ff, d_op_abs, d_rst_abs, d_sum_abs;
  logic signed [SUM_W:0] d_op, d_rst, d_sum;
  logic [SUM_W+1:0] op_x2, op_x4, rst_x1, rst_x3;
  logic [HOLD_W-1:0] hold_ff;
  logic op_ff, ct_ff, efd_hit, ct_hit, hisec, slope_ok, op_nxt;

  assign op_abs = e.op_sum[SUM_W-1] ? SUM_W'(-e.op_sum) : SUM_W'(e.op_sum);
  assign d_op = $signed({1'b0, op_abs}) - $signed({1'b0, op_prev_ff});
  assign d_rst = $signed({1'b0, e.rst_sum}) - $signed({1'b0, rst_prev_ff});
  assign d_sum = d_op + d_rst;
  assign d_op_abs = SUM_W'(d_op[SUM_W] ? -d_op : d_op);
  assign d_rst_abs = SUM_W'(d_rst[SUM_W] ? -d_rst : d_rst);
  assign d_sum_abs = SUM_W'(d_sum[SUM_W] ? -d_sum : d_sum);
  // Restraint jumps while operate barely moves: through fault, CT not yet saturated
  assign efd_hit = !d_rst[SUM_W] && (d_rst_abs > EFD_DELTA) && (d_op_abs < (d_rst_abs >> 2));
  assign ct_hit = (d_op_abs > CT_DELTA) && (d_sum_abs <= CT_TOL);
  assign hisec = efd_hit || (hold_ff != '0);
  assign op_x2 = {1'b0, op_abs, 1'b0};
  assign op_x4 = {op_abs, 2'b00};
  assign rst_x1 = {2'b00, e.rst_sum};
  assign rst_x3 = {2'b00, e.rst_sum} + {1'b0, e.rst_sum, 1'b0};
  // Slope 1/2 normally, 3/4 in high-security mode
  assign slope_ok = hisec ? (op_x4 > rst_x3) : (op_x2 > rst_x1);
  assign op_nxt = (op_abs > SUM_W'(e.pickup)) && slope_ok;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_ff <= 1'b0;
      ct_ff <= 1'b0;
      op_prev_ff <= '0;
      rst_prev_ff <= '0;
      hold_ff <= '0;
    end else begin
      ct_ff <= e.strobe && ct_hit;
      if (e.strobe) begin
        op_ff <= op_nxt;
        op_prev_ff <= op_abs;
        rst_prev_ff <= e.rst_sum;
      end
      if (e.strobe && efd_hit) begin
        hold_ff <= HOLD_W'(HOLD_CYC);
      end else if (hold_ff != '0) begin
        hold_ff <= hold_ff - 1'b1;
      end
    end
  end

  assign e.op_flag = op_ff;
  assign e.ct_evt = ct_ff;
  assign e.efd_flag = hold_ff != '0;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_efd_detect: assert property (e.strobe && efd_hit |=> e.efd_flag)
    else $error("external fault not flagged after detection");
  a_high_slope: assert property (e.strobe && hisec && !(op_x4 > rst_x3) |=> !e.op_flag)
    else $error("operated below the high slope");
  a_op_pickup: assert property (e.strobe |=> (!e.op_flag || $past(op_abs > SUM_W'(e.pickup))))
    else $error("operated below pickup");
  a_ct_event: assert property (e.strobe && ct_hit |=> e.ct_evt ##1 !e.ct_evt)
    else $error("CT failure event missing or not one cycle");
endmodule

// ### bzs_elem_if.sv
// Carrier between the zone selection core and one differential element
`timescale 1ns/1ps
interface bzs_elem_if;
  import bzs_pkg::*;
  logic strobe;
  logic signed [SUM_W-1:0] op_sum;
  logic [SUM_W-1:0] rst_sum;
  logic [CUR_W-1:0] pickup;
  logic op_flag;
  logic efd_flag;
  logic ct_evt;
  modport zone (output strobe, op_sum, rst_sum, pickup, input op_flag, efd_flag, ct_evt);
  modport elem (input strobe, op_sum, rst_sum, pickup, output op_flag, efd_flag, ct_evt);
endinterface

// ### bzs_pkg.sv
// Constants, register map and helper function of the bus zone selection block
// Contract
// - Evaluate every terminal condition first, then route currents into the selected zones.
// - Terminal current joins its zone while its condition holds, leaves when false.
// - Trip toward a terminal only while its condition is true.
// - Disconnect reads open only for no-contact 0 with nc-contact 1; else closed.
// - Breaker contact in a condition drops the current while the breaker is open.
// - Three independent check zones over all terminals, usable to supervise main zones.
// - Check zone output asserts for internal faults, stays low for external ones.
// - Flag equal and opposite operate/restraint changes as CT failure; usable in trips.
// - Tie breaker closing onto a fault must not trip both adjacent zones.
// - Twenty-one current inputs, each assignable among six differential zones.
// - A zone may be configured across a tie breaker between its two CTs.
// - Detect external faults within 2 ms from rates of change; then raise the slope.
package bzs_pkg;
  localparam int N_TERM = 21;
  localparam int N_ZONE = 6;
  localparam int N_CHK = 3;
  localparam int N_ELEM = N_ZONE + N_CHK;
  localparam int N_DISC = 16;
  localparam int DIDX_W = 4;
  localparam int ZSEL_W = 3;
  localparam int CUR_W = 16;
  localparam int SUM_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TCFG_W = 13;
  localparam int CTRL_W = 2;
  localparam int STAT_W = 21;
  localparam int SUP_W = 12;
  localparam int TIE_CW = 3;
  localparam int HOLD_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ZONE_STATE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TRIP_STATE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DISC_STATE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PICKUP = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ZONE_SUP = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TERM_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_TERM_END = 8'h94;

  // Field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_CTBLK = 1;
  localparam int ST_TRIP = 0;
  localparam int ST_CT = 6;
  localparam int ST_CHK = 12;
  localparam int ST_EFD = 15;
  localparam int TC_ZONE = 0;
  localparam int TC_DIDX = 3;
  localparam int TC_DUSE = 7;
  localparam int TC_BUSE = 8;
  localparam int TC_TIE = 9;
  localparam int TC_CHK = 10;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h1;
  localparam logic [STAT_W-1:0] MASK_RST = 21'h000000;
  localparam logic [CUR_W-1:0] PICKUP_RST = 16'h0100;
  localparam logic [SUP_W-1:0] SUP_RST = 12'h000;
  localparam logic [TCFG_W-1:0] TCFG_RST = 13'h0000;

  // Detection thresholds, in current units
  localparam logic [SUM_W-1:0] EFD_DELTA = 24'h000400;
  localparam logic [SUM_W-1:0] CT_DELTA = 24'h000200;
  localparam logic [SUM_W-1:0] CT_TOL = 24'h000040;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int EFD_TIME_US = 2000;
  localparam int EFD_MAX_CYC = EFD_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [TIE_CW-1:0] TIE_WIN = 3'h4;

  function automatic logic [SUM_W-1:0] bzs_abs_cur(input logic [CUR_W-1:0] x);
    return SUM_W'(x[CUR_W-1] ? CUR_W'(~x + 1'b1) : x);
  endfunction
endpackage

// ### bzs_zone_sel.sv
// Bus zone selection: terminal conditions, zone routing, trip enables and supervision
`timescale 1ns/1ps
module bzs_zone_sel import bzs_pkg::*; #(
  parameter int HISEC_HOLD_CYC = EFD_MAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic sample_valid,
  input wire logic [N_TERM*CUR_W-1:0] term_current,
  input wire logic [N_DISC-1:0] disconnect_no_contact,
  input wire logic [N_DISC-1:0] disconnect_nc_contact,
  input wire logic [N_TERM-1:0] breaker_closed_contact,
  output logic [N_ZONE*N_TERM-1:0] zone_member,
  output logic [N_TERM-1:0] term_trip,
  output logic [N_ZONE-1:0] zone_trip,
  output logic [N_CHK-1:0] check_zone_op,
  output logic [N_ZONE-1:0] ct_alarm,
  output logic [N_ZONE-1:0] ext_fault,
  output logic irq
);
  logic [CTRL_W-1:0] ctrl_ff;
  logic [STAT_W-1:0] status_ff, mask_ff, stat_set, stat_clr;
  logic [CUR_W-1:0] pickup_ff;
  logic [SUP_W-1:0] zone_sup_ff;
  logic [TCFG_W-1:0] term_cfg_w [N_TERM];
  logic [N_TERM*CUR_W-1:0] cur_ff;
  logic [N_TERM-1:0] eq, eq_ff, tie_block, term_trip_ff, term_trip_nxt, bkr_closed;
  logic [N_DISC-1:0] disc_closed;
  logic [N_ZONE*N_TERM-1:0] member_ff, member_nxt;
  logic [N_CHK*N_TERM-1:0] chk_member;
  logic [N_ZONE-1:0] zone_trip_ff, zone_trip_nxt, zop, zefd, zct, efd_ff;
  logic [N_ZONE+1:0] zt_pad;
  logic [N_CHK-1:0] cop, check_op_ff;
  logic [DATA_W-1:0] rdata_ff, rd_mux;
  logic [4:0] term_idx;
  logic stg_b_ff, stg_c_ff, irq_ff, sample_take, hit_term;
  logic wr_ctrl, wr_status, wr_mask, wr_pickup, wr_sup;

  bzs_contact_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .disc_no_raw(disconnect_no_contact),
    .disc_nc_raw(disconnect_nc_contact),
    .bkr_raw(breaker_closed_contact),
    .disc_closed(disc_closed),
    .bkr_closed(bkr_closed)
  );

  // Register decode
  assign hit_term = (addr >= OFS_TERM_BASE) && (addr < OFS_TERM_END) && (addr[1:0] == 2'h0);
  assign term_idx = 5'((addr - OFS_TERM_BASE) >> 2);
  assign wr_ctrl = wr_en && (addr == OFS_CTRL);
  assign wr_status = wr_en && (addr == OFS_STATUS);
  assign wr_mask = wr_en && (addr == OFS_MASK);
  assign wr_pickup = wr_en && (addr == OFS_PICKUP);
  assign wr_sup = wr_en && (addr == OFS_ZONE_SUP);
  assign sample_take = sample_valid && ctrl_ff[CTRL_EN];

  assign rd_mux = hit_term ? DATA_W'(term_cfg_w[term_idx]) :
    (addr == OFS_CTRL) ? DATA_W'(ctrl_ff) :
    (addr == OFS_STATUS) ? DATA_W'(status_ff) :
    (addr == OFS_MASK) ? DATA_W'(mask_ff) :
    (addr == OFS_ZONE_STATE) ? DATA_W'({efd_ff, check_op_ff, zone_trip_ff}) :
    (addr == OFS_TRIP_STATE) ? DATA_W'(term_trip_ff) :
    (addr == OFS_DISC_STATE) ? DATA_W'(disc_closed) :
    (addr == OFS_PICKUP) ? DATA_W'(pickup_ff) :
    (addr == OFS_ZONE_SUP) ? DATA_W'(zone_sup_ff) : '0;

  // Events land in stage C; a set in the same cycle as a clear survives
  assign stat_set = stg_c_ff ? {zefd, cop, zct, zone_trip_nxt} : '0;
  assign stat_clr = wr_status ? wdata[STAT_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
      status_ff <= '0;
      mask_ff <= MASK_RST;
      pickup_ff <= PICKUP_RST;
      zone_sup_ff <= SUP_RST;
      rdata_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_ff <= wdata[CTRL_W-1:0];
      if (wr_mask) mask_ff <= wdata[STAT_W-1:0];
      if (wr_pickup) pickup_ff <= wdata[CUR_W-1:0];
      if (wr_sup) zone_sup_ff <= wdata[SUP_W-1:0];
      status_ff <= (status_ff & ~stat_clr) | stat_set;
      rdata_ff <= rd_en ? rd_mux : '0;
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // Per-terminal condition evaluation
  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    logic [TCFG_W-1:0] cfg_ff;
    logic [TIE_CW-1:0] tie_cnt_ff;
    logic bkr_prev_ff, disc_ok, bkr_ok, bkr_rise, cfg_wr;
    logic [ZSEL_W-1:0] tz;

    assign cfg_wr = wr_en && hit_term && (term_idx == 5'(t));
    assign term_cfg_w[t] = cfg_ff;
    assign tz = cfg_ff[TC_ZONE +: ZSEL_W];
    assign disc_ok = !cfg_ff[TC_DUSE] || disc_closed[cfg_ff[TC_DIDX +: DIDX_W]];
    assign bkr_ok = !cfg_ff[TC_BUSE] || bkr_closed[t];
    assign bkr_rise = bkr_closed[t] && !bkr_prev_ff;
    // Overlapped tie CT is kept out of both zones while the breaker closes
    // The closing interval itself is blocked, not only the ones after it
    assign tie_block[t] = cfg_ff[TC_TIE] && ((tie_cnt_ff != '0) || bkr_rise);
    assign eq[t] = disc_ok && bkr_ok && !tie_block[t];
    assign term_trip_nxt[t] = eq_ff[t] && zt_pad[tz];

    for (genvar z = 0; z < N_ZONE; z++) begin : g_zm
      // Any terminal may go to any zone, including a zone spanning a tie breaker
      assign member_nxt[z*N_TERM+t] = eq[t] && (tz == ZSEL_W'(z + 1));

      a_member_eq: assert property (@(posedge clk) disable iff (!reset_n)
        member_ff[z*N_TERM+t] |-> eq_ff[t])
        else $error("terminal in zone with false condition");
    end
    for (genvar c = 0; c < N_CHK; c++) begin : g_cm
      assign chk_member[c*N_TERM+t] = cfg_ff[TC_CHK + c];
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        cfg_ff <= TCFG_RST;
        tie_cnt_ff <= '0;
        bkr_prev_ff <= 1'b0;
      end else begin
        if (cfg_wr) cfg_ff <= wdata[TCFG_W-1:0];
        if (sample_take) begin
          bkr_prev_ff <= bkr_closed[t];
          if (bkr_rise && cfg_ff[TC_TIE]) begin
            tie_cnt_ff <= TIE_WIN;
          end else if (tie_cnt_ff != '0) begin
            tie_cnt_ff <= tie_cnt_ff - 1'b1;
          end
        end
      end
    end

    a_bkr_drop: assert property (@(posedge clk) disable iff (!reset_n)
      sample_take && cfg_ff[TC_BUSE] && !bkr_closed[t] |=> !eq_ff[t])
      else $error("open breaker left terminal in zone");
    a_tie_excl: assert property (@(posedge clk) disable iff (!reset_n)
      sample_take && tie_block[t] |=> !eq_ff[t] && !term_trip_nxt[t])
      else $error("tie terminal kept during closing window");
  end

  // Stage A takes conditions and samples; B feeds the elements; C updates trips
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur_ff <= '0;
      eq_ff <= '0;
      member_ff <= '0;
      stg_b_ff <= 1'b0;
      stg_c_ff <= 1'b0;
    end else begin
      stg_b_ff <= sample_take;
      stg_c_ff <= stg_b_ff;
      if (sample_take) begin
        cur_ff <= term_current;
        eq_ff <= eq;
        member_ff <= member_nxt;
      end
    end
  end

  bzs_elem_if elem_bus [N_ELEM] ();

  for (genvar z = 0; z < N_ELEM; z++) begin : g_elem
    logic [N_TERM-1:0] msk;
    logic signed [SUM_W-1:0] op_acc;
    logic [SUM_W-1:0] rst_acc;

    if (z < N_ZONE) begin : g_main
      logic [1:0] sel;
      logic chk_ok;
      assign msk = member_ff[z*N_TERM +: N_TERM];
      assign sel = zone_sup_ff[2*z +: 2];
      assign chk_ok = (sel == 2'h0) || cop[sel - 2'h1];
      // A CT failure, latched or just seen, can block the zone
      assign zone_trip_nxt[z] = zop[z] && chk_ok &&
        !(ctrl_ff[CTRL_CTBLK] && (status_ff[ST_CT+z] || zct[z]));
      assign zop[z] = elem_bus[z].op_flag;
      assign zefd[z] = elem_bus[z].efd_flag;
      assign zct[z] = elem_bus[z].ct_evt;

      a_check_sup: assert property (@(posedge clk) disable iff (!reset_n)
        stg_c_ff && !chk_ok |=> !zone_trip_ff[z])
        else $error("zone tripped without its check zone");
    end else begin : g_chk
      // Check zones ignore the disconnect image, so a wrong image cannot fool both
      assign msk = chk_member[(z-N_ZONE)*N_TERM +: N_TERM];
      assign cop[z-N_ZONE] = elem_bus[z].op_flag;
    end

    always_comb begin
      op_acc = '0;
      rst_acc = '0;
      for (int t = 0; t < N_TERM; t++) begin
        if (msk[t]) begin
          op_acc = op_acc + SUM_W'($signed(cur_ff[t*CUR_W +: CUR_W]));
          rst_acc = rst_acc + bzs_abs_cur(cur_ff[t*CUR_W +: CUR_W]);
        end
      end
    end

    assign elem_bus[z].strobe = stg_b_ff;
    assign elem_bus[z].op_sum = op_acc;
    assign elem_bus[z].rst_sum = rst_acc;
    assign elem_bus[z].pickup = pickup_ff;

    bzs_diff_elem #(
      .HOLD_CYC(HISEC_HOLD_CYC)
    ) u_elem (
      .clk(clk),
      .reset_n(reset_n),
      .e(elem_bus[z])
    );
  end

  assign zt_pad = {1'b0, zone_trip_nxt, 1'b0};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      zone_trip_ff <= '0;
      term_trip_ff <= '0;
      check_op_ff <= '0;
      efd_ff <= '0;
    end else if (stg_c_ff) begin
      zone_trip_ff <= zone_trip_nxt;
      term_trip_ff <= term_trip_nxt;
      check_op_ff <= cop;
      efd_ff <= zefd;
    end
  end

  assign rdata = rdata_ff;
  assign zone_member = member_ff;
  assign term_trip = term_trip_ff;
  assign zone_trip = zone_trip_ff;
  assign check_zone_op = check_op_ff;
  assign ct_alarm = status_ff[ST_CT +: N_ZONE];
  assign ext_fault = efd_ff;
  assign irq = irq_ff;

  a_two_step: assert property (@(posedge clk) disable iff (!reset_n)
    sample_take |=> stg_b_ff && (member_ff == $past(member_nxt)))
    else $error("zones routed before conditions evaluated");
  a_interval_upd: assert property (@(posedge clk) disable iff (!reset_n)
    sample_take |-> ##2 stg_c_ff ##1 (term_trip_ff == $past(term_trip_nxt)))
    else $error("trip enables not refreshed in the interval");
  a_trip_needs_eq: assert property (@(posedge clk) disable iff (!reset_n)
    stg_c_ff |=> (term_trip_ff & ~$past(eq_ff)) == '0)
    else $error("trip toward terminal with false condition");
  a_ct_block: assert property (@(posedge clk) disable iff (!reset_n)
    stg_c_ff && ctrl_ff[CTRL_CTBLK] |=>
      (zone_trip_ff & $past(status_ff[ST_CT +: N_ZONE])) == '0)
    else $error("zone tripped with CT failure blocking");
  a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> (status_ff & $past(stat_set)) == $past(stat_set))
    else $error("status event lost");
  a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) |-> irq_ff == $past(|(status_ff & mask_ff)))
    else $error("interrupt does not follow masked status");
  a_rdata_once: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(rd_en) |-> rdata_ff == '0)
    else $error("read data outside its cycle");

  c_zone_trip: cover property (@(posedge clk) disable iff (!reset_n) |zone_trip_ff);
  c_ct_alarm: cover property (@(posedge clk) disable iff (!reset_n) |zct);
  c_ext_fault: cover property (@(posedge clk) disable iff (!reset_n) |efd_ff);
  c_tie_window: cover property (@(posedge clk) disable iff (!reset_n) |tie_block);
endmodule

// ### bzs_zone_sel_test.sv
// Self-checking testbench of the bus zone selection block
`timescale 1ns/1ps
module bzs_zone_sel_test;
  import bzs_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic [DATA_W-1:0] rdata;
  logic sample_valid = 0;
  logic [N_TERM*CUR_W-1:0] term_current = '0;
  logic [N_DISC-1:0] disc_no = '0;
  logic [N_DISC-1:0] disc_nc = '0;
  logic [N_TERM-1:0] bkr_closed = '1;
  logic [N_ZONE*N_TERM-1:0] zone_member;
  logic [N_TERM-1:0] term_trip;
  logic [N_ZONE-1:0] zone_trip;
  logic [N_CHK-1:0] check_zone_op;
  logic [N_ZONE-1:0] ct_alarm;
  logic [N_ZONE-1:0] ext_fault;
  logic irq;
  logic [DATA_W-1:0] rv;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  // Short hold keeps the high-security window inside a few intervals
  bzs_zone_sel #(.HISEC_HOLD_CYC(50)) DUT (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_valid(sample_valid),
    .term_current(term_current), .disconnect_no_contact(disc_no),
    .disconnect_nc_contact(disc_nc), .breaker_closed_contact(bkr_closed),
    .zone_member(zone_member), .term_trip(term_trip), .zone_trip(zone_trip),
    .check_zone_op(check_zone_op), .ct_alarm(ct_alarm), .ext_fault(ext_fault), .irq(irq));

  initial forever #50 clk = ~clk;

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1;
    @(posedge clk);
    rd_en <= 0;
    #1 rv = rdata;
  endtask

  // Contacts need the synchronisers flushed before the interval starts
  task automatic smp();
    repeat (3) @(posedge clk);
    sample_valid <= 1;
    @(posedge clk);
    sample_valid <= 0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic cur(input int t, input logic [CUR_W-1:0] v);
    term_current[t*CUR_W +: CUR_W] <= v;
  endtask

  task automatic t_regs();
    chk("member_rst", 32'(zone_member[20:0]), 32'h0);
    chk("irq_rst", 32'(irq), 32'h0);
    rd(OFS_CTRL);
    chk("ctrl", rv, 32'h1);
    rd(OFS_PICKUP);
    chk("pickup", rv, 32'h100);
    rd(OFS_MASK);
    chk("mask", rv, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20);
    chk("unmapped", rv, 32'h0);
  endtask

  task automatic t_disc();
    disc_no <= 16'h000C;
    disc_nc <= 16'hFFFA;
    repeat (3) @(posedge clk);
    rd(OFS_DISC_STATE);
    chk("disc_state", rv, 32'h0000000D);
  endtask

  task automatic t_assign();
    wr(8'h40, 32'h481);
    wr(8'h44, 32'h101);
    wr(8'h48, 32'h401);
    wr(8'h4C, 32'h301);
    wr(OFS_MASK, 32'h1);
    bkr_closed <= ~21'h8;
    cur(0, 16'h1000);
    smp();
    chk("member", 32'(zone_member[20:0]), 32'h7);
    chk("member_hi", 32'(|zone_member[125:21]), 32'h0);
    chk("zone_trip", 32'(zone_trip), 32'h1);
    chk("term_trip", 32'(term_trip), 32'h7);
    chk("check_op", 32'(check_zone_op), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rd(OFS_ZONE_STATE);
    chk("zone_state", rv, 32'h41);
  endtask

  task automatic t_irq();
    cur(0, 16'h0);
    smp();
    chk("zone_trip_off", 32'(zone_trip), 32'h0);
    rd(OFS_STATUS);
    chk("status", rv, 32'h1001);
    wr(OFS_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq_masked", 32'(irq), 32'h0);
    wr(OFS_MASK, 32'h1000);
    repeat (2) @(posedge clk);
    #1 chk("irq_chk", 32'(irq), 32'h1);
    wr(OFS_STATUS, 32'h1001);
    repeat (2) @(posedge clk);
    #1 chk("irq_clr", 32'(irq), 32'h0);
    rd(OFS_STATUS);
    chk("status_clr", rv, 32'h0);
  endtask

  task automatic t_drop();
    disc_nc <= 16'hFFFB;
    bkr_closed <= ~21'h0A;
    cur(2, 16'h1000);
    smp();
    chk("member_drop", 32'(zone_member[20:0]), 32'h4);
    chk("zone_trip2", 32'(zone_trip), 32'h1);
    chk("term_trip2", 32'(term_trip), 32'h4);
    chk("check_op2", 32'(check_zone_op), 32'h1);
  endtask

  task automatic t_tie();
    bkr_closed <= ~21'h02;
    smp();
    chk("tie_member", 32'(zone_member[20:0]), 32'h4);
    chk("tie_trip", 32'(term_trip), 32'h4);
    repeat (5) smp();
    chk("tie_join", 32'(zone_member[20:0]), 32'hC);
    chk("tie_trip_on", 32'(term_trip), 32'hC);
  endtask

  task automatic t_ext();
    cur(2, 16'h0);
    smp();
    cur(0, 16'hF000);
    cur(2, 16'h1000);
    cur(3, 16'hF000);
    smp();
    chk("ext_fault", 32'(ext_fault), 32'h1);
    chk("ext_no_trip", 32'(zone_trip), 32'h0);
    chk("ext_check", 32'(check_zone_op), 32'h0);
  endtask

  // Open CT on terminal 3 while trips are gated by CT status
  task automatic t_ct();
    wr(OFS_CTRL, 32'h3);
    cur(3, 16'h0);
    smp();
    chk("ct_alarm", 32'(ct_alarm), 32'h1);
    chk("ct_block", 32'(zone_trip), 32'h0);
  endtask

  task automatic t_disable();
    wr(OFS_CTRL, 32'h0);
    bkr_closed <= '1;
    smp();
    chk("disabled", 32'(zone_member[20:0]), 32'hC);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_ZONE_SUP, 32'h2);
    smp();
    chk("sup_member", 32'(zone_member[20:0]), 32'hE);
    chk("sup_block", 32'(zone_trip), 32'h0);
    wr(OFS_ZONE_SUP, 32'h1);
    cur(0, 16'h0);
    smp();
    chk("sup_pass", 32'(zone_trip), 32'h1);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    #1;
    t_regs();
    t_disc();
    t_assign();
    t_irq();
    t_drop();
    t_tie();
    t_ext();
    t_ct();
    t_disable();
    close_out();
  end
endmodule
